// File: logic/eam_core.v
// Effective-address unit: fetches prefix, opcode and operand bytes, then reports
// the effective address or operand. Assumes an external opcode decoder answers
// MODE, RMW and LONG_FORM combinationally from OPCODE in the same cycle.
`timescale 1ns/1ps
`include "eam_defines.vh"
module eam_core (
   input  wire        MCLK,
   input  wire        RST,
   input  wire        START,
   input  wire [15:0] PC_IN,
   input  wire        PC_LOAD,
   input  wire [7:0]  X_REG,
   input  wire [7:0]  Y_REG,
   input  wire [3:0]  MODE,
   input  wire        RMW,
   input  wire        LONG_FORM,
   output reg  [7:0]  OPCODE,
   output reg         MEM_RD,
   output reg  [15:0] MEM_ADDR,
   input  wire [7:0]  MEM_DATA,
   output reg         DONE,
   output reg         ILLEGAL,
   output reg  [15:0] EA,
   output reg  [7:0]  IMM_VAL,
   output reg         IMM_VALID,
   output reg  [15:0] PC_OUT,
   output reg  [3:0]  INSTR_LEN,
   output reg         BUSY
);
   localparam S_IDLE = 3'd0;
   localparam S_OPC  = 3'd1;
   localparam S_DEC  = 3'd2;
   localparam S_OPR  = 3'd3;
   localparam S_PTR  = 3'd4;
   localparam S_FIN  = 3'd5;

   reg [2:0]  st_q;
   reg [15:0] pc_q;
   reg [1:0]  pfx_q;      // 0 none, 1 y, 2 ind, 3 ind_y
   reg [1:0]  opr_left_q;
   reg [1:0]  ptr_left_q;
   reg [15:0] opr_q;
   reg [15:0] ptr_q;
   reg        wait_q;
   reg        use_y_q;
   reg        ind_q;
   reg        ptr_word_q;
   reg        idx_q;
   reg        rel_q;
   reg        imm_q;
   reg [3:0]  len_q;

   wire [7:0] idx_val = use_y_q ? Y_REG : X_REG;

   // Signed relative target from address of next instruction
   function [15:0] rel_target;
      input [15:0] pc;
      input [7:0]  off;
      begin
         rel_target = pc + {{8{off[7]}}, off};
      end
   endfunction

   // Prefix codes held in pfx_q
   localparam P_NONE  = 2'd0;
   localparam P_Y     = 2'd1;
   localparam P_IND   = 2'd2;
   localparam P_IND_Y = 2'd3;

   // Modes whose address is built from an index register
   function is_indexed;
      input [3:0] mode;
      begin
         is_indexed = (mode == `EAM_M_IDX_0) ||
                      (mode == `EAM_M_IDX_S) ||
                      (mode == `EAM_M_IDX_L);
      end
   endfunction

   // Modes that an indirect prefix turns into pointer forms
   function can_indirect;
      input [3:0] mode;
      begin
         can_indirect = (mode == `EAM_M_DIR_S) ||
                        (mode == `EAM_M_DIR_L) ||
                        (mode == `EAM_M_IDX_S) ||
                        (mode == `EAM_M_IDX_L) ||
                        (mode == `EAM_M_BIT) ||
                        (mode == `EAM_M_BIT_REL) ||
                        (mode == `EAM_M_REL);
      end
   endfunction

   // Long forms that read-modify-write opcodes may not use
   function is_long_mode;
      input [3:0] mode;
      input       long_form;
      begin
         is_long_mode = (mode == `EAM_M_DIR_L) ||
                        (mode == `EAM_M_IDX_L) ||
                        long_form;
      end
   endfunction

   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         st_q       <= S_IDLE;
         pc_q       <= `EAM_PC_RESET;
         pfx_q      <= P_NONE;
         opr_left_q <= 2'd0;
         ptr_left_q <= 2'd0;
         opr_q      <= 16'h0000;
         ptr_q      <= 16'h0000;
         wait_q     <= 1'b0;
         use_y_q    <= 1'b0;
         ind_q      <= 1'b0;
         ptr_word_q <= 1'b0;
         idx_q      <= 1'b0;
         rel_q      <= 1'b0;
         imm_q      <= 1'b0;
         len_q      <= 4'h0;
         OPCODE     <= 8'h00;
         MEM_RD     <= 1'b0;
         MEM_ADDR   <= 16'h0000;
         DONE       <= 1'b0;
         ILLEGAL    <= 1'b0;
         EA         <= 16'h0000;
         IMM_VAL    <= 8'h00;
         IMM_VALID  <= 1'b0;
         PC_OUT     <= `EAM_PC_RESET;
         INSTR_LEN  <= 4'h0;
         BUSY       <= 1'b0;
      end else begin
         // Strobes are single-cycle pulses
         DONE   <= 1'b0;
         MEM_RD <= 1'b0;
         case (st_q)
            S_IDLE: begin
               // A load wins; a start in the same cycle is ignored
               if (PC_LOAD) begin
                  pc_q <= PC_IN;
               end else if (START) begin
                  pfx_q     <= P_NONE;
                  len_q     <= 4'h0;
                  ILLEGAL   <= 1'b0;
                  IMM_VALID <= 1'b0;
                  MEM_RD    <= 1'b1;
                  MEM_ADDR  <= pc_q;
                  BUSY      <= 1'b1;
                  wait_q    <= 1'b1;
                  st_q      <= S_OPC;
               end
            end
            S_OPC: begin
               // Read data is valid one cycle after the strobe
               if (wait_q) begin
                  wait_q <= 1'b0;
               end else begin
                  pc_q  <= pc_q + 16'h0001;
                  len_q <= len_q + 4'h1;
                  if (MEM_DATA == `EAM_PFX_Y) begin
                     pfx_q    <= P_Y;
                     MEM_RD   <= 1'b1;
                     MEM_ADDR <= pc_q + 16'h0001;
                     wait_q   <= 1'b1;
                  end else if (MEM_DATA == `EAM_PFX_IND) begin
                     // Only one prefix kept; a later prefix replaces an earlier
                     pfx_q    <= P_IND;
                     MEM_RD   <= 1'b1;
                     MEM_ADDR <= pc_q + 16'h0001;
                     wait_q   <= 1'b1;
                  end else if (MEM_DATA == `EAM_PFX_IND_Y) begin
                     pfx_q    <= P_IND_Y;
                     MEM_RD   <= 1'b1;
                     MEM_ADDR <= pc_q + 16'h0001;
                     wait_q   <= 1'b1;
                  end else begin
                     OPCODE <= MEM_DATA;
                     st_q   <= S_DEC;
                  end
               end
            end
            S_DEC: begin
               // prefix 90 selects Y; prefix 91 indirect Y
               use_y_q    <= (pfx_q == P_Y) || (pfx_q == P_IND_Y);
               ind_q      <= ((pfx_q == P_IND) || (pfx_q == P_IND_Y)) && can_indirect(MODE);
               // long pointer is a word; short is a byte
               ptr_word_q <= LONG_FORM;
               idx_q      <= is_indexed(MODE);
               rel_q      <= (MODE == `EAM_M_REL);
               imm_q      <= (MODE == `EAM_M_IMM);
               opr_q      <= 16'h0000;
               ptr_q      <= 16'h0000;
               if (RMW && is_long_mode(MODE, LONG_FORM)) begin
                  // Refused before any operand fetch, so PC stops after the opcode
                  ILLEGAL   <= 1'b1;
                  DONE      <= 1'b1;
                  BUSY      <= 1'b0;
                  st_q      <= S_IDLE;
                  PC_OUT    <= pc_q;
                  INSTR_LEN <= len_q;
               end else begin
                  // inherent and no-offset fetch nothing more
                  // long forms fetch two bytes, one when indirect; extra bytes
                  case (MODE)
                     `EAM_M_INH: begin
                        opr_left_q <= 2'd0;
                     end
                     `EAM_M_IDX_0: begin
                        opr_left_q <= 2'd0;
                     end
                     `EAM_M_DIR_L: begin
                        // Indirect long forms carry only a byte pointer address
                        opr_left_q <= pfx_q[1] ? 2'd1 : 2'd2;
                     end
                     `EAM_M_IDX_L: begin
                        opr_left_q <= pfx_q[1] ? 2'd1 : 2'd2;
                     end
                     default: begin
                        opr_left_q <= 2'd1;
                     end
                  endcase
                  st_q <= S_OPR;
               end
            end
            S_OPR: begin
               if (opr_left_q == 2'd0) begin
                  // pointer read from the page-zero address held in the operand byte
                  if (ind_q) begin
                     ptr_left_q <= ptr_word_q ? 2'd2 : 2'd1;
                     MEM_RD     <= 1'b1;
                     MEM_ADDR   <= {8'h00, opr_q[7:0]};
                     wait_q     <= 1'b1;
                     st_q       <= S_PTR;
                  end else begin
                     st_q <= S_FIN;
                  end
               end else if (!MEM_RD && !wait_q) begin
                  MEM_RD   <= 1'b1;
                  MEM_ADDR <= pc_q;
                  wait_q   <= 1'b1;
               end else if (wait_q && !MEM_RD) begin
                  wait_q     <= 1'b0;
                  opr_q      <= {opr_q[7:0], MEM_DATA};
                  pc_q       <= pc_q + 16'h0001;
                  len_q      <= len_q + 4'h1;
                  opr_left_q <= opr_left_q - 2'd1;
               end
            end
            S_PTR: begin
               if (wait_q && !MEM_RD) begin
                  wait_q     <= 1'b0;
                  ptr_q      <= {ptr_q[7:0], MEM_DATA};
                  ptr_left_q <= ptr_left_q - 2'd1;
                  if (ptr_left_q == 2'd1) begin
                     st_q <= S_FIN;
                  end else begin
                     // Pointer word wraps inside page zero
                     MEM_RD   <= 1'b1;
                     MEM_ADDR <= {8'h00, opr_q[7:0] + 8'h01};
                     wait_q   <= 1'b1;
                  end
               end
            end
            S_FIN: begin
               DONE      <= 1'b1;
               BUSY      <= 1'b0;
               st_q      <= S_IDLE;
               PC_OUT    <= pc_q;
               INSTR_LEN <= len_q;
               if (imm_q) begin
                  IMM_VAL   <= opr_q[7:0];
                  IMM_VALID <= 1'b1;
                  EA        <= 16'h0000;
               end else if (rel_q) begin
                  EA <= rel_target(pc_q, ind_q ? ptr_q[7:0] : opr_q[7:0]);
               end else if (idx_q) begin
                  EA <= (ind_q ? ptr_q : opr_q) + {8'h00, idx_val};
               end else if (ind_q) begin
                  EA <= ptr_q;
               end else begin
                  // short stays in page zero; long word
                  EA <= opr_q;
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// File: shared/eam_defines.vh
// Constants for the effective-address and operand-fetch unit.
// Assumes a byte-wide memory read port with a one-cycle read latency.
`ifndef EAM_DEFINES_VH
`define EAM_DEFINES_VH
`define EAM_PFX_Y      8'h90
`define EAM_PFX_IND_Y  8'h91
`define EAM_PFX_IND    8'h92
// Base mode codes given on MODE
`define EAM_M_INH      4'h0
`define EAM_M_IMM      4'h1
`define EAM_M_DIR_S    4'h2
`define EAM_M_DIR_L    4'h3
`define EAM_M_IDX_0    4'h4
`define EAM_M_IDX_S    4'h5
`define EAM_M_IDX_L    4'h6
`define EAM_M_REL      4'h7
`define EAM_M_BIT      4'h8
`define EAM_M_BIT_REL  4'h9
`define EAM_PC_RESET   16'h0000
`endif

// File: test/eam_core_bench.sv
// Self-checking bench for eam_core with a byte memory on the fetch port.
// The bench stands in for the opcode decoder by holding MODE, RMW, LONG_FORM.
`timescale 1ns/1ps
`include "eam_defines.vh"
module eam_core_bench;
   reg         mclk = 1'b0, rst = 1'b1, start = 1'b0, pc_load = 1'b0, rmw = 1'b0, lng = 1'b0;
   reg  [15:0] pc_in = 16'h0000;
   reg  [3:0]  mode = 4'h0;
   wire [7:0]  opc, mdat, imm;
   wire        rd, done, ill, immv, busy;
   wire [15:0] madr, ea, pco;
   wire [3:0]  len;
   integer     n_fail = 0, n_tests = 0, i;
   eam_core dut (.MCLK(mclk), .RST(rst), .START(start), .PC_IN(pc_in), .PC_LOAD(pc_load), .X_REG(8'hff),
      .Y_REG(8'h3c), .MODE(mode), .RMW(rmw), .LONG_FORM(lng), .OPCODE(opc), .MEM_RD(rd), .MEM_ADDR(madr),
      .MEM_DATA(mdat), .DONE(done), .ILLEGAL(ill), .EA(ea), .IMM_VAL(imm), .IMM_VALID(immv), .PC_OUT(pco),
      .INSTR_LEN(len), .BUSY(busy));
   eam_mem mem (.clk(mclk), .rd(rd), .addr(madr), .data(mdat));
   initial forever #2.5 mclk = ~mclk;
   task summarize;
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input [31:0] nm, input [15:0] e, input [15:0] g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("ERROR %0s exp %h got %h", nm, e, g);
      end
   endtask
   task ld3(input [15:0] a, input [7:0] b0, input [7:0] b1, input [7:0] b2);
      mem.m[a] = b0;
      mem.m[a + 16'h0001] = b1;
      mem.m[a + 16'h0002] = b2;
   endtask
   // One decode at pc; an unknown expected address skips that compare
   task go(input [15:0] pc, input [3:0] md, input [1:0] rl, input [15:0] e, input [3:0] n);
      @(negedge mclk);
      pc_in = pc;
      mode = md;
      {rmw, lng} = rl;
      pc_load = 1'b1;
      @(negedge mclk) pc_load = 1'b0;
      start = 1'b1;
      @(negedge mclk) start = 1'b0;
      for (i = 0; i < 40 && done !== 1'b1; i = i + 1) @(negedge mclk);
      if (i == 40) begin
         n_fail = n_fail + 1;
         summarize;
      end
      chk("ill", {15'h0000, rl[1]}, {15'h0000, ill});
      chk("busy", 16'h0000, {15'h0000, busy});
      if (!rl[1]) begin
         chk("len", {12'h000, n}, {12'h000, len});
         chk("pc", pc + {12'h000, n}, pco);
         if (e !== 16'hxxxx) chk("ea", e, ea);
      end
   endtask
   task t_inh;
      ld3(16'h0100, 8'h9d, 8'h00, 8'h00);
      go(16'h0100, `EAM_M_INH, 2'b00, 16'hxxxx, 4'h1);
      chk("opc", 16'h009d, {8'h00, opc});
      chk("immv", 16'h0000, {15'h0000, immv});
   endtask
   task t_imm;
      ld3(16'h0200, 8'ha6, 8'h55, 8'h00);
      go(16'h0200, `EAM_M_IMM, 2'b00, 16'hxxxx, 4'h2);
      chk("imm", 16'h0055, {8'h00, imm});
      chk("immv", 16'h0001, {15'h0000, immv});
   endtask
   task t_long;
      ld3(16'h0300, 8'hc6, 8'h12, 8'h34);
      go(16'h0300, `EAM_M_DIR_L, 2'b00, 16'h1234, 4'h3);
      ld3(16'h0a00, 8'h3c, 8'h12, 8'h34);
      go(16'h0a00, `EAM_M_DIR_L, 2'b10, 16'hxxxx, 4'h0);
   endtask
   task t_index;
      ld3(16'h0400, 8'he6, 8'hff, 8'h00);
      go(16'h0400, `EAM_M_IDX_S, 2'b00, 16'h01fe, 4'h2);
      ld3(16'h0500, 8'h90, 8'hf6, 8'h00);
      go(16'h0500, `EAM_M_IDX_0, 2'b00, 16'h003c, 4'h2);
      chk("opc", 16'h00f6, {8'h00, opc});
      ld3(16'h0510, 8'hf6, 8'h00, 8'h00);
      go(16'h0510, `EAM_M_IDX_0, 2'b00, 16'h00ff, 4'h1);
   endtask
   task t_indirect;
      ld3(16'h0600, 8'h92, 8'hc6, 8'h40);
      ld3(16'h0040, 8'h77, 8'hab, 8'hcd);
      go(16'h0600, `EAM_M_DIR_S, 2'b00, 16'h0077, 4'h3);
      ld3(16'h0700, 8'h92, 8'hc6, 8'h41);
      go(16'h0700, `EAM_M_DIR_S, 2'b01, 16'habcd, 4'h3);
   endtask
   task t_rel;
      ld3(16'h0900, 8'h27, 8'h80, 8'h00);
      go(16'h0900, `EAM_M_REL, 2'b00, 16'h0882, 4'h2);
   endtask
   initial begin
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      t_inh;
      t_imm;
      t_long;
      t_index;
      t_indirect;
      t_rel;
      summarize;
   end
endmodule

// File: test/eam_core_checker.sv
// Port-level checks for eam_core, bound into every instance.
// Assumes MODE, RMW and LONG_FORM are held steady through each decode.
`timescale 1ns/1ps
`include "eam_defines.vh"
module eam_core_chk (
   input wire        MCLK,
   input wire        RST,
   input wire        START,
   input wire        PC_LOAD,
   input wire        BUSY,
   input wire [3:0]  MODE,
   input wire        RMW,
   input wire        LONG_FORM,
   input wire [7:0]  X_REG,
   input wire        MEM_RD,
   input wire [15:0] MEM_ADDR,
   input wire        DONE,
   input wire        ILLEGAL,
   input wire [15:0] EA,
   input wire [15:0] PC_OUT,
   input wire [3:0]  INSTR_LEN
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   reg [15:0] pc_q;
   reg [3:0]  nrd_q;
   // First read of a decode is its start address; reads are counted per decode
   always @(posedge MCLK or posedge RST)
      if (RST) begin
         pc_q  <= 16'h0000;
         nrd_q <= 4'h0;
      end else begin
         if (MEM_RD && nrd_q == 4'h0) pc_q <= MEM_ADDR;
         if (START && !BUSY && !PC_LOAD) nrd_q <= 4'h0;
         else if (MEM_RD) nrd_q <= nrd_q + 4'h1;
      end
   a_page_zero: assert property (DONE && MODE == `EAM_M_DIR_S && !LONG_FORM |-> EA[15:8] == 8'h00)
      else $error("short direct left page zero");
   a_pc_next: assert property (DONE && !ILLEGAL |-> PC_OUT == pc_q + {12'h000, INSTR_LEN})
      else $error("next pc not start plus length");
   a_inh_fetch: assert property (DONE && MODE == `EAM_M_INH |-> nrd_q == INSTR_LEN)
      else $error("inherent fetched extra bytes");
   a_imm_len: assert property (DONE && MODE == `EAM_M_IMM |-> nrd_q == INSTR_LEN && INSTR_LEN inside {2, 3})
      else $error("immediate length wrong");
   a_rmw_long: assert property (DONE && RMW && (MODE == `EAM_M_DIR_L || MODE == `EAM_M_IDX_L) |-> ILLEGAL)
      else $error("long read-modify-write accepted");
   a_idx0_x: assert property (DONE && MODE == `EAM_M_IDX_0 && INSTR_LEN == 4'h1 |-> EA == {8'h00, X_REG})
      else $error("no-offset index address wrong");
   a_start_fetch: assert property (START && !BUSY && !PC_LOAD |=> MEM_RD)
      else $error("no fetch after start");
   a_idx_sum: assert property (DONE && MODE == `EAM_M_IDX_S && !LONG_FORM && INSTR_LEN == 4'h2 |-> EA <= 16'h01fe)
      else $error("short index beyond range");
endmodule
bind eam_core eam_core_chk u_chk (.MCLK(MCLK), .RST(RST), .START(START), .PC_LOAD(PC_LOAD), .BUSY(BUSY),
   .MODE(MODE), .RMW(RMW), .LONG_FORM(LONG_FORM), .X_REG(X_REG), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
   .DONE(DONE), .ILLEGAL(ILLEGAL), .EA(EA), .PC_OUT(PC_OUT), .INSTR_LEN(INSTR_LEN));

// File: test/eam_mem.sv
// Byte-wide fetch memory for the effective-address unit.
// Data follows a read strobe by one cycle; between reads the lines toggle.
`timescale 1ns/1ps
module eam_mem (
   input  wire        clk,
   input  wire        rd,
   input  wire [15:0] addr,
   output reg  [7:0]  data
);
   reg [7:0] m [0:65535];
   initial data = 8'h00;
   // Toggling keeps a late capture from picking up a stale byte
   always @(posedge clk)
      if (rd) data <= m[addr];
      else data <= ~data;
endmodule
